/* File: anpr_regs.sv */
// Advertisement and link partner ability registers
`timescale 1ns/100ps
module anpr_regs (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire logic strap_fast_fd_i,
    input wire logic strap_fast_hd_i,
    input wire anpr_pkg::anpr_mgmt_req_type mgmt_req_i,
    input wire anpr_pkg::anpr_rx_page_type rx_page_i,
    input wire logic neg_complete_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    output logic [15:0] advert_word_o,
    output logic [15:0] partner_word_o,
    output logic [1:0] pause_status_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] negotiation_advertisement;
    logic [15:0] partner_ability_base_page;
    logic strap_done;
    logic [15:0] rd_data;
    logic rd_valid;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic hit_advert;
    wire logic hit_partner;
    wire logic wr_advert;
    wire logic rd_strobe;
    wire logic next_page_mode;
    wire logic load_base;
    wire logic load_next;
    logic [15:0] strapped_advert;
    wire logic [15:0] next_advert;
    wire logic [15:0] next_partner;
    wire logic [15:0] next_rd_data;

    assign hit_advert = mgmt_req_i.addr == anpr_pkg::ADDR_ADVERT;
    assign hit_partner = mgmt_req_i.addr == anpr_pkg::ADDR_PARTNER;
    assign wr_advert = mgmt_req_i.wr && hit_advert;
    assign rd_strobe = mgmt_req_i.rd;

    // ------------------------------------------------------------------
    // Advertisement word
    // ------------------------------------------------------------------
    // Straps are caught on the first enabled edge after reset (an advert write on that edge wins), not in
    // the reset branch, so the reset value stays a constant.
    always_comb begin
        strapped_advert = negotiation_advertisement;
        strapped_advert[anpr_pkg::BIT_FAST_FD] = strap_fast_fd_i;
        strapped_advert[anpr_pkg::BIT_FAST_HD] = strap_fast_hd_i;
    end

    // Fixed bits 14, 12 and 9 are masked out of every write
    assign next_advert = wr_advert ?
                         (mgmt_req_i.wdata & anpr_pkg::ADVERT_WR_MASK) :
                         !strap_done ? strapped_advert :
                         negotiation_advertisement;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            negotiation_advertisement <= anpr_pkg::ADVERT_RESET;
            strap_done <= 1'b0;
        end else if (clk_en_i) begin
            negotiation_advertisement <= next_advert;
            strap_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Partner ability word
    // ------------------------------------------------------------------
    // A fresh base page always wins, since it marks a new negotiation.
    assign next_page_mode = neg_complete_i &&
        negotiation_advertisement[anpr_pkg::BIT_NEXT_PAGE] &&
        partner_ability_base_page[anpr_pkg::BIT_NEXT_PAGE];
    assign load_base = rx_page_i.base_valid;
    assign load_next = !rx_page_i.base_valid && rx_page_i.next_valid &&
                       next_page_mode;
    assign next_partner = load_base ?
                          (rx_page_i.word & anpr_pkg::PARTNER_BASE_MASK) :
                          load_next ? rx_page_i.word :
                          partner_ability_base_page;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            partner_ability_base_page <= anpr_pkg::PARTNER_RESET;
        end else if (clk_en_i) begin
            partner_ability_base_page <= next_partner;
        end
    end

    // ------------------------------------------------------------------
    // Management read path
    // ------------------------------------------------------------------
    assign next_rd_data = !rd_strobe ? rd_data :
                          hit_advert ? negotiation_advertisement :
                          hit_partner ? partner_ability_base_page :
                          anpr_pkg::READ_ZERO;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data <= anpr_pkg::READ_ZERO;
            rd_valid <= 1'b0;
        end else if (clk_en_i) begin
            rd_data <= next_rd_data;
            rd_valid <= rd_strobe;
        end
    end

    // ------------------------------------------------------------------
    // Pause resolution
    // ------------------------------------------------------------------
    // Duplex is not checked here; the link side ignores pause in half
    // duplex anyway.
    anpr_pause_resolve u_pause (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i),
        .complete_i(neg_complete_i),
        .local_pause_i(negotiation_advertisement[anpr_pkg::BIT_PAUSE]),
        .local_asym_i(negotiation_advertisement[anpr_pkg::BIT_ASYM_PAUSE]),
        .part_pause_i(partner_ability_base_page[anpr_pkg::BIT_PAUSE]),
        .part_asym_i(partner_ability_base_page[anpr_pkg::BIT_ASYM_PAUSE]),
        .pause_o(pause_status_o)
    );

    assign rd_data_o = rd_data;
    assign rd_valid_o = rd_valid;
    assign advert_word_o = negotiation_advertisement;
    assign partner_word_o = partner_ability_base_page;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    rsvd_bit14_a: assert property (
        negotiation_advertisement[anpr_pkg::BIT_ACK] == 1'b0)
        else $error("advert bit 14 not zero");

    rsvd_bit12_a: assert property (
        negotiation_advertisement[anpr_pkg::BIT_RSVD_12] == 1'b0)
        else $error("advert bit 12 not zero");

    // A next page carries its own bit 12, so only base loads clear it
    base_bit12_a: assert property (
        clk_en_i && rx_page_i.base_valid |=>
        partner_ability_base_page[anpr_pkg::BIT_RSVD_12] == 1'b0)
        else $error("base page bit 12 not zero");

    four_pair_zero_a: assert property (
        clk_en_i && wr_advert |=>
        negotiation_advertisement[anpr_pkg::BIT_FOUR_PAIR] == 1'b0)
        else $error("four-pair advert bit set");

    advert_write_a: assert property (
        clk_en_i && wr_advert |=>
        negotiation_advertisement ==
        ($past(mgmt_req_i.wdata) & anpr_pkg::ADVERT_WR_MASK))
        else $error("advert write lost");

    selector_reset_a: assert property (
        !strap_done |->
        negotiation_advertisement[anpr_pkg::SEL_MSB:anpr_pkg::SEL_LSB] ==
        anpr_pkg::SELECTOR_RESET)
        else $error("selector reset value wrong");

    strap_load_a: assert property (
        clk_en_i && !strap_done && !wr_advert |=>
        negotiation_advertisement[anpr_pkg::BIT_FAST_FD] ==
        $past(strap_fast_fd_i) &&
        negotiation_advertisement[anpr_pkg::BIT_FAST_HD] ==
        $past(strap_fast_hd_i))
        else $error("strap not loaded");

    base_load_a: assert property (
        clk_en_i && rx_page_i.base_valid |=>
        partner_ability_base_page ==
        ($past(rx_page_i.word) & anpr_pkg::PARTNER_BASE_MASK))
        else $error("base page not loaded");

    next_page_a: assert property (
        clk_en_i && load_next |=>
        partner_ability_base_page == $past(rx_page_i.word))
        else $error("next page not loaded");

    next_blocked_a: assert property (
        clk_en_i && !rx_page_i.base_valid && !next_page_mode |=>
        $stable(partner_ability_base_page))
        else $error("next page loaded outside next page mode");

    read_back_a: assert property (
        clk_en_i && rd_strobe && hit_advert |=>
        rd_valid_o && rd_data_o == $past(negotiation_advertisement))
        else $error("advert read wrong");

    pause_sym_a: assert property (
        clk_en_i && neg_complete_i &&
        negotiation_advertisement[anpr_pkg::BIT_PAUSE] &&
        partner_ability_base_page[anpr_pkg::BIT_PAUSE] |=>
        pause_status_o == 2'h3)
        else $error("symmetric pause not resolved");

    pause_idle_a: assert property (
        clk_en_i && !neg_complete_i |=> pause_status_o == anpr_pkg::PAUSE_NONE)
        else $error("pause resolved before completion");

    four_pair_fixed_a: assert property (
        negotiation_advertisement[anpr_pkg::BIT_FOUR_PAIR] == 1'b0)
        else $error("four-pair advert bit not zero");

    advert_hold_a: assert property (
        clk_en_i && strap_done && !wr_advert |=>
        $stable(negotiation_advertisement))
        else $error("advert changed without a write");

    advert_freeze_a: assert property (
        !clk_en_i |=> $stable(negotiation_advertisement))
        else $error("advert changed while frozen");

    partner_freeze_a: assert property (
        !clk_en_i |=> $stable(partner_ability_base_page) &&
        $stable(rd_data_o) && $stable(rd_valid_o))
        else $error("state changed while frozen");

    fault_write_a: assert property (
        clk_en_i && wr_advert |=>
        negotiation_advertisement[anpr_pkg::BIT_REMOTE_FAULT] ==
        $past(mgmt_req_i.wdata[anpr_pkg::BIT_REMOTE_FAULT]))
        else $error("remote fault advert not written");

    asym_write_a: assert property (
        clk_en_i && wr_advert |=>
        negotiation_advertisement[anpr_pkg::BIT_ASYM_PAUSE] ==
        $past(mgmt_req_i.wdata[anpr_pkg::BIT_ASYM_PAUSE]))
        else $error("asymmetric pause advert not written");

    sym_write_a: assert property (
        clk_en_i && wr_advert |=>
        negotiation_advertisement[anpr_pkg::BIT_PAUSE] ==
        $past(mgmt_req_i.wdata[anpr_pkg::BIT_PAUSE]))
        else $error("pause advert not written");

    slow_fd_write_a: assert property (
        clk_en_i && wr_advert |=>
        negotiation_advertisement[anpr_pkg::BIT_SLOW_FD] ==
        $past(mgmt_req_i.wdata[anpr_pkg::BIT_SLOW_FD]))
        else $error("slow full duplex advert not written");

    slow_hd_write_a: assert property (
        clk_en_i && wr_advert |=>
        negotiation_advertisement[anpr_pkg::BIT_SLOW_HD] ==
        $past(mgmt_req_i.wdata[anpr_pkg::BIT_SLOW_HD]))
        else $error("slow half duplex advert not written");

    selector_write_a: assert property (
        clk_en_i && wr_advert |=>
        negotiation_advertisement[anpr_pkg::SEL_MSB:anpr_pkg::SEL_LSB] ==
        $past(mgmt_req_i.wdata[anpr_pkg::SEL_MSB:anpr_pkg::SEL_LSB]))
        else $error("selector not written");

    strap_hd_a: assert property (
        clk_en_i && !strap_done && !wr_advert |=>
        negotiation_advertisement[anpr_pkg::BIT_FAST_HD] ==
        $past(strap_fast_hd_i))
        else $error("fast half duplex strap not loaded");

    pause_tx_a: assert property (
        clk_en_i && neg_complete_i &&
        !negotiation_advertisement[anpr_pkg::BIT_PAUSE] &&
        negotiation_advertisement[anpr_pkg::BIT_ASYM_PAUSE] &&
        partner_ability_base_page[anpr_pkg::BIT_PAUSE] &&
        partner_ability_base_page[anpr_pkg::BIT_ASYM_PAUSE] |=>
        pause_status_o == 2'h1)
        else $error("transmit pause not resolved");

    pause_rx_a: assert property (
        clk_en_i && neg_complete_i &&
        negotiation_advertisement[anpr_pkg::BIT_PAUSE] &&
        negotiation_advertisement[anpr_pkg::BIT_ASYM_PAUSE] &&
        !partner_ability_base_page[anpr_pkg::BIT_PAUSE] &&
        partner_ability_base_page[anpr_pkg::BIT_ASYM_PAUSE] |=>
        pause_status_o == 2'h2)
        else $error("receive pause not resolved");

    cov_write_c: cover property (clk_en_i && wr_advert ##1 rd_valid_o);
    cov_base_c: cover property (clk_en_i && rx_page_i.base_valid);
    cov_next_c: cover property (clk_en_i && load_next);
    cov_pause_c: cover property (pause_status_o == 2'h2);

endmodule : anpr_regs

/* File: anpr_pkg.sv */
// Constants and carrier types for the advertisement and partner registers
package anpr_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_ADVERT = 5'h04;
    localparam logic [4:0] ADDR_PARTNER = 5'h05;

    // ------------------------------------------------------------------
    // Bit positions, shared by both words
    // ------------------------------------------------------------------
    localparam int BIT_NEXT_PAGE = 15;
    localparam int BIT_ACK = 14;
    localparam int BIT_REMOTE_FAULT = 13;
    localparam int BIT_RSVD_12 = 12;
    localparam int BIT_ASYM_PAUSE = 11;
    localparam int BIT_PAUSE = 10;
    localparam int BIT_FOUR_PAIR = 9;
    localparam int BIT_FAST_FD = 8;
    localparam int BIT_FAST_HD = 7;
    localparam int BIT_SLOW_FD = 6;
    localparam int BIT_SLOW_HD = 5;
    localparam int SEL_MSB = 4;
    localparam int SEL_LSB = 0;

    // ------------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] ADVERT_WR_MASK = 16'hADFF;
    localparam logic [15:0] ADVERT_RESET = 16'h0061;
    localparam logic [4:0] SELECTOR_RESET = 5'h01;
    localparam logic [15:0] PARTNER_BASE_MASK = 16'hEFFF;
    localparam logic [15:0] PARTNER_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // ------------------------------------------------------------------
    // Pause resolution status layout
    // ------------------------------------------------------------------
    localparam int PAUSE_RX_IDX = 1;
    localparam int PAUSE_TX_IDX = 0;
    localparam logic [1:0] PAUSE_NONE = 2'h0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } anpr_mgmt_req_type;

    typedef struct packed {
        logic base_valid;
        logic next_valid;
        logic [15:0] word;
    } anpr_rx_page_type;

endpackage : anpr_pkg

/* File: anpr_pause_resolve.sv */
// Pause resolution between local and partner pause advertisements
`timescale 1ns/100ps
module anpr_pause_resolve (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire logic complete_i,
    input wire logic local_pause_i,
    input wire logic local_asym_i,
    input wire logic part_pause_i,
    input wire logic part_asym_i,
    output logic [1:0] pause_o
);

    // ------------------------------------------------------------------
    // Resolution table
    // ------------------------------------------------------------------
    wire logic both_sym;
    wire logic tx_only;
    wire logic rx_only;
    wire logic [1:0] next_pause;

    assign both_sym = local_pause_i && part_pause_i;
    assign tx_only = !local_pause_i && local_asym_i && part_pause_i &&
                     part_asym_i;
    assign rx_only = local_pause_i && local_asym_i && !part_pause_i &&
                     part_asym_i;
    // Nothing is resolved until negotiation has finished
    assign next_pause = !complete_i ? anpr_pkg::PAUSE_NONE :
                        {both_sym || rx_only, both_sym || tx_only};

    // ------------------------------------------------------------------
    // Status flop
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pause_o <= anpr_pkg::PAUSE_NONE;
        end else if (clk_en_i) begin
            pause_o <= next_pause;
        end
    end

endmodule : anpr_pause_resolve

/* File: anpr_link_partner.sv */
// Behavioural link partner that delivers received ability words
`timescale 1ns/100ps
module anpr_link_partner (
    input wire logic ref_clk_i,
    output anpr_pkg::anpr_rx_page_type rx_page_o
);
    // ------------------------------------------------------------------
    // Page delivery
    // ------------------------------------------------------------------
    initial begin
        rx_page_o = '0;
    end

    // Word is inverted after the pulse so a stale value never looks valid
    task automatic send(input logic nxt, input logic [15:0] w);
        @(posedge ref_clk_i);
        rx_page_o <= '{base_valid: !nxt, next_valid: nxt, word: w};
        @(posedge ref_clk_i);
        rx_page_o <= '{base_valid: 1'b0, next_valid: 1'b0, word: ~w};
    endtask : send
endmodule : anpr_link_partner

/* File: anpr_regs_tb.sv */
// Self-checking bench for the advertisement and partner registers
`timescale 1ns/100ps
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        bad_count++; \
        $display("mismatch t=%0t got %h exp %h", $time, a, b); \
    end \
end
module anpr_regs_tb;
    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic strap_fd = 1'b0;
    logic strap_hd = 1'b0;
    logic neg_complete = 1'b0;
    anpr_pkg::anpr_mgmt_req_type req = '0;
    anpr_pkg::anpr_rx_page_type rx_page;
    logic [15:0] rd_data;
    logic [15:0] adv_word;
    logic [15:0] part_word;
    logic rd_valid;
    logic [1:0] pause;
    int bad_count = 0;
    int samples_checked = 0;
    int seed = 92548;
    int m_adv = 0;
    int m_part = 0;
    int exp_q[$];

    initial begin
        forever #2 clk = ~clk;
    end

    anpr_regs u_dut (
        .ref_clk_i(clk),
        .arst_n_i(arst_n),
        .clk_en_i(clk_en),
        .strap_fast_fd_i(strap_fd),
        .strap_fast_hd_i(strap_hd),
        .mgmt_req_i(req),
        .rx_page_i(rx_page),
        .neg_complete_i(neg_complete),
        .rd_data_o(rd_data),
        .rd_valid_o(rd_valid),
        .advert_word_o(adv_word),
        .partner_word_o(part_word),
        .pause_status_o(pause)
    );

    anpr_link_partner u_lp (
        .ref_clk_i(clk),
        .rx_page_o(rx_page)
    );

    // ------------------------------------------------------------------
    // Reference model and tasks
    // ------------------------------------------------------------------
    function automatic int pause_of(input int a, input int p);
        if (!neg_complete) return 0;
        if (a[10] && p[10]) return 3;
        if (!a[10] && a[11] && p[10] && p[11]) return 1;
        if (a[10] && a[11] && !p[10] && p[11]) return 2;
        return 0;
    endfunction : pause_of

    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        strap_fd <= 1'($random(seed));
        strap_hd <= 1'($random(seed));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        m_adv = int'(anpr_pkg::ADVERT_RESET) | (int'(strap_fd) << 8) |
                (int'(strap_hd) << 7);
        m_part = 0;
        @(posedge clk);
        #1;
        `CHK(adv_word, 16'(m_adv))
        `CHK(part_word, 16'h0000)
        `CHK(pause, 2'h0)
        `CHK(rd_valid, 1'b0)
    endtask : do_reset

    // Bits 14, 12 and 9 never hold a one, whatever is written
    task automatic wr(input logic [4:0] a, input logic [15:0] d,
                      input logic r);
        int old;
        old = m_adv;
        @(posedge clk);
        req <= '{wr: 1'b1, rd: r, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        if (a == anpr_pkg::ADDR_ADVERT && clk_en) begin
            m_adv = d & ~((1 << 14) | (1 << 12) | (1 << 9));
        end
        #1;
        `CHK(adv_word, 16'(m_adv))
        if (r) begin
            `CHK(rd_valid, 1'b1)
            `CHK(rd_data, 16'(old))
        end
    endtask : wr

    task automatic rd(input logic [4:0] a, input int exp);
        int e;
        exp_q.push_back(exp);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'($random(seed))};
        @(posedge clk);
        req <= '0;
        e = exp_q.pop_front();
        #1;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, 16'(e))
        @(posedge clk);
        #1;
        `CHK(rd_valid, 1'b0)
    endtask : rd

    task automatic send(input logic nxt, input logic [15:0] w);
        u_lp.send(nxt, w);
        if (!nxt) begin
            m_part = w & ~(1 << 12);
        end else if (neg_complete && m_adv[15] && m_part[15]) begin
            m_part = w;
        end
        #1;
        `CHK(part_word, 16'(m_part))
    endtask : send

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        wr(anpr_pkg::ADDR_ADVERT, 16'hFFFF, 1'b0);
        rd(anpr_pkg::ADDR_ADVERT, m_adv);
        wr(anpr_pkg::ADDR_ADVERT, 16'h0000, 1'b0);
        rd(anpr_pkg::ADDR_ADVERT, m_adv);
        repeat (20) begin
            wr(anpr_pkg::ADDR_ADVERT, 16'($random(seed)), 1'b0);
            rd(anpr_pkg::ADDR_ADVERT, m_adv);
        end
        wr(anpr_pkg::ADDR_ADVERT, 16'h1234, 1'b1);
        wr(5'h07, 16'hFFFF, 1'b0);
        rd(5'h07, 0);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(anpr_pkg::ADDR_ADVERT, 16'h8C01, 1'b0);
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (10) begin
            send(1'b0, 16'($random(seed)));
            rd(anpr_pkg::ADDR_PARTNER, m_part);
        end
        // Next page words only land once both ends asked for them and negotiation is complete
        wr(anpr_pkg::ADDR_ADVERT, 16'h8001, 1'b0);
        send(1'b0, 16'h9FFF);
        send(1'b1, 16'h5A5A);
        @(posedge clk);
        neg_complete <= 1'b1;
        send(1'b1, 16'h1234);
        send(1'b1, 16'h7777);
        rd(anpr_pkg::ADDR_PARTNER, m_part);
        // Every advert write is followed by a fresh negotiation
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            neg_complete <= 1'b0;
            wr(anpr_pkg::ADDR_ADVERT, 16'(((i & 3) << 10) | 1), 1'b0);
            send(1'b0, 16'((i & 12) << 8));
            @(posedge clk);
            neg_complete <= 1'(i >> 4);
            repeat (3) @(posedge clk);
            #1;
            `CHK(pause, 2'(pause_of(m_adv, m_part)))
        end
        do_reset();
        rd(anpr_pkg::ADDR_ADVERT, m_adv);
        close_out();
    end

    // Whole run is about 500 cycles (about 2000 ns); this limit is generous
    initial begin
        #40000;
        bad_count++;
        close_out();
    end
endmodule : anpr_regs_tb
